// ===== hdl/dwc_pkg.sv
// shared constants for the waveform core and its serial host
//----------------------------------------------------------------------
// Operation
// - 28-bit accumulator adds increment each cycle, wraps
// - increment comes from freq register a or b
// - frequency switch never clears the accumulator
// - 12-bit selected offset added to accumulator top
// - two offset registers, lsb is 1/4096 cycle
// - upper 12 phase bits address sine table
// - table gives 10-bit codes from 12-bit address
// - mode bit D1 chooses sine table or not
// - shift one bit per falling sclk, 16 form word
// - bits accepted only while frame sync low
// - long frames carry successive 16-bit words
// - host raises frame only after 16th fall
// - sclk high when frame sync falls
// - any sclk idle level tolerated, framed bits only
// - reset bit clears accumulator, output midscale
// - reset bit keeps registers, host loads them
// - host holds reset bit during initialisation
// - output data 7-8 cycles after reset clears
// - register change reaches output in 7-8 cycles, mode bit D1 in 4
// - top bits 00 address the control register
// - control bits except mode sampled one stage
// - full-width load: low 14 then high 14
//----------------------------------------------------------------------
package dwc_pkg;
  localparam int WORD_W = 16;
  localparam int FREQ_W = 28;
  localparam int PHASE_W = 12;
  localparam int DAC_W = 10;
  localparam int HALF_W = 14;
  localparam int BITS_PER_WORD = 16;
  localparam int CLK_PERIOD_NS = 25;
  // address field of a serial word
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_FREQ_A = 2'h1;
  localparam logic [1:0] ADDR_FREQ_B = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;
  localparam int PHASE_REG_BIT = 13;
  // control register bit positions
  localparam int FULL_WIDTH_BIT = 13;
  localparam int HALF_SEL_BIT = 12;
  localparam int FREQ_SEL_BIT = 11;
  localparam int PHASE_SEL_BIT = 10;
  localparam int RESET_BIT = 8;
  localparam int MODE_BIT = 1;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [9:0] MIDSCALE = 10'h200;
  localparam logic [9:0] AMP_MAX = 10'h1ff;
  localparam logic [11:0] HALF_TURN = 12'h800;
  localparam int OUT_PIPE = 3;
  localparam int SCLK_DIV = 2;
  // host serialiser states
  typedef enum logic [1:0] {
    DWC_IDLE = 2'b00,
    DWC_HIGH = 2'b01,
    DWC_LOW = 2'b10
  } dwc_hstate_t;
endpackage

// ===== hdl/dwc_if.sv
// three-wire serial link between host and waveform core
`timescale 1ns/100ps
interface dwc_if;
  logic sclk;
  logic frame_sync_n;
  logic serial_din;
  modport dev (input sclk, input frame_sync_n, input serial_din);
  modport host (output sclk, output frame_sync_n, output serial_din);
endinterface

// ===== hdl/dwc_host.sv
// host end: serialises 16-bit words onto the three-wire link
`timescale 1ns/100ps
module dwc_host
  import dwc_pkg::*;
#(
  parameter int DIV = SCLK_DIV
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic WR_VALID,
  input wire logic [WORD_W-1:0] WR_DATA,
  output logic WR_READY,
  output logic BUSY,
  dwc_if.host LINK
);
  typedef struct packed {
    dwc_hstate_t st;
    logic [7:0] div;
    logic [3:0] left;
    logic [WORD_W-1:0] shift;
    logic sclk;
    logic fsn;
    logic din;
  } dwc_host_t;

  dwc_host_t s_r, s_nxt;
  logic tick;
  logic last;

  //----------------------------------------------------------------------
  // handshake
  //----------------------------------------------------------------------
  // half-period enable and word acceptance
  assign tick = (s_r.div == 8'(DIV - 1));
  assign last = (s_r.left == 4'h0);
  assign WR_READY = (s_r.st == DWC_IDLE) || (s_r.st == DWC_LOW && tick && last);
  assign BUSY = (s_r.st != DWC_IDLE);
  assign LINK.sclk = s_r.sclk;
  assign LINK.frame_sync_n = s_r.fsn;
  assign LINK.serial_din = s_r.din;

  //----------------------------------------------------------------------
  // serialiser
  //----------------------------------------------------------------------
  // frame falls with sclk high and first bit, later bits change on rising sclk only
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = (s_r.st == DWC_IDLE || tick) ? 8'h00 : s_r.div + 8'h01;
    unique case (s_r.st)
      DWC_IDLE: begin
        s_nxt.sclk = 1'b1;
        s_nxt.fsn = 1'b1;
        if (WR_VALID) begin
          s_nxt.fsn = 1'b0;
          s_nxt.din = WR_DATA[WORD_W-1];
          s_nxt.shift = {WR_DATA[WORD_W-2:0], 1'b0};
          s_nxt.left = 4'(BITS_PER_WORD - 1);
          s_nxt.st = DWC_HIGH;
        end
      end
      DWC_HIGH: begin
        if (tick) begin
          s_nxt.sclk = 1'b0;
          s_nxt.st = DWC_LOW;
        end
      end
      DWC_LOW: begin
        if (tick) begin
          s_nxt.sclk = 1'b1;
          s_nxt.st = DWC_HIGH;
          if (!last) begin
            s_nxt.din = s_r.shift[WORD_W-1];
            s_nxt.shift = {s_r.shift[WORD_W-2:0], 1'b0};
            s_nxt.left = s_r.left - 4'h1;
          end else if (WR_VALID) begin
            s_nxt.din = WR_DATA[WORD_W-1];
            s_nxt.shift = {WR_DATA[WORD_W-2:0], 1'b0};
            s_nxt.left = 4'(BITS_PER_WORD - 1);
          end else begin
            s_nxt.fsn = 1'b1;
            s_nxt.st = DWC_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = DWC_IDLE;
        s_nxt.sclk = 1'b1;
        s_nxt.fsn = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '{st: DWC_IDLE, div: 8'h00, left: 4'h0, shift: 16'h0000,
               sclk: 1'b1, fsn: 1'b1, din: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== hdl/dwc_core.sv
// device end: serial word receiver, registers and phase-to-amplitude path
`timescale 1ns/100ps
module dwc_core
  import dwc_pkg::*;
#(
  parameter int PIPE = OUT_PIPE
) (
  input wire logic CLOCK,
  input wire logic NRST,
  dwc_if.dev LINK,
  output logic [DAC_W-1:0] DAC_CODE,
  output logic WORD_SEEN
);
  typedef struct packed {
    // receiver
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic [WORD_W-1:0] shift;
    logic word_vld;
    logic [WORD_W-1:0] word;
    // register file
    logic [WORD_W-1:0] ctrl;
    logic [FREQ_W-1:0] freq_a;
    logic [FREQ_W-1:0] freq_b;
    logic [PHASE_W-1:0] ofs_a;
    logic [PHASE_W-1:0] ofs_b;
    logic [HALF_W-1:0] low_stage;
    logic low_pend;
    // synthesis pipeline
    logic [WORD_W-1:0] ctrl_s;
    logic [1:0] rst_d;
    logic [FREQ_W-1:0] inc;
    logic [PHASE_W-1:0] ofs;
    logic [PHASE_W-1:0] ofs_d;
    logic [FREQ_W-1:0] acc;
    logic [PHASE_W-1:0] phase;
    logic [DAC_W-1:0] code;
    logic [PIPE-1:0][DAC_W-1:0] pipe;
  } dwc_core_t;

  // registered state, its next value and word decode
  dwc_core_t s_r, s_nxt;
  logic sclk_fall;
  logic [1:0] addr;
  logic [HALF_W-1:0] payload;

  //----------------------------------------------------------------------
  // amplitude functions
  //----------------------------------------------------------------------
  // parabolic half-wave sine, phase 0 sits at midscale
  function automatic logic [DAC_W-1:0] dwc_sine(input logic [PHASE_W-1:0] a);
    logic [PHASE_W-1:0] p;
    logic [23:0] y;
    logic [DAC_W-1:0] m;
    p = {1'b0, a[PHASE_W-2:0]};
    y = 24'(p) * 24'(HALF_TURN - p);
    m = (y[20:11] > AMP_MAX) ? AMP_MAX : y[20:11];
    return a[PHASE_W-1] ? MIDSCALE - m : MIDSCALE + m;
  endfunction

  // linear ramp up then down when the table is bypassed
  function automatic logic [DAC_W-1:0] dwc_tri(input logic [PHASE_W-1:0] a);
    return a[PHASE_W-1] ? ~a[PHASE_W-2:1] : a[PHASE_W-2:1];
  endfunction

  //----------------------------------------------------------------------
  // link decode
  //----------------------------------------------------------------------
  // falling sclk seen only inside a frame
  assign sclk_fall = s_r.sclk_q && !LINK.sclk && !LINK.frame_sync_n;
  // fields of the completed word
  assign addr = s_r.word[ADDR_HI:ADDR_LO];
  assign payload = s_r.word[HALF_W-1:0];
  // outputs straight from flops
  assign DAC_CODE = s_r.pipe[PIPE-1];
  assign WORD_SEEN = s_r.word_vld;

  //----------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_q = LINK.sclk;
    s_nxt.word_vld = 1'b0;

    //------------------------------------------------------------------
    // receiver
    //------------------------------------------------------------------
    // serial shifter, msb first, count cleared outside a frame
    if (LINK.frame_sync_n) begin
      s_nxt.bit_cnt = 4'h0;
    end else if (sclk_fall) begin
      s_nxt.shift = {s_r.shift[WORD_W-2:0], LINK.serial_din};
      s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      if (s_r.bit_cnt == 4'(BITS_PER_WORD - 1)) begin
        s_nxt.word = {s_r.shift[WORD_W-2:0], LINK.serial_din};
        s_nxt.word_vld = 1'b1;
      end
    end

    //------------------------------------------------------------------
    // register file
    //------------------------------------------------------------------
    // register writes from a completed word
    if (s_r.word_vld) begin
      unique case (addr)
        ADDR_CTRL: begin
          s_nxt.ctrl = s_r.word;
          s_nxt.low_pend = 1'b0;
        end
        ADDR_FREQ_A, ADDR_FREQ_B: begin
          if (s_r.ctrl[FULL_WIDTH_BIT] && !s_r.low_pend) begin
            s_nxt.low_stage = payload;
            s_nxt.low_pend = 1'b1;
          end else begin
            s_nxt.low_pend = 1'b0;
            if (addr == ADDR_FREQ_A) begin
              s_nxt.freq_a = upd(s_r.freq_a);
            end else begin
              s_nxt.freq_b = upd(s_r.freq_b);
            end
          end
        end
        ADDR_PHASE: begin
          if (s_r.word[PHASE_REG_BIT]) begin
            s_nxt.ofs_b = s_r.word[PHASE_W-1:0];
          end else begin
            s_nxt.ofs_a = s_r.word[PHASE_W-1:0];
          end
        end
      endcase
    end

    //------------------------------------------------------------------
    // synthesis path
    //------------------------------------------------------------------
    // stages: select, accumulate, offset, amplitude, then the delay line
    // control sampled one stage ahead of the synthesis path
    s_nxt.ctrl_s = s_r.ctrl;
    s_nxt.inc = s_r.ctrl[FREQ_SEL_BIT] ? s_r.freq_b : s_r.freq_a;
    s_nxt.ofs = s_r.ctrl[PHASE_SEL_BIT] ? s_r.ofs_b : s_r.ofs_a;
    // offset and reset bit delayed to match the frequency path latency, mode bit not delayed
    s_nxt.ofs_d = s_r.ofs;
    s_nxt.rst_d = {s_r.rst_d[0], s_r.ctrl_s[RESET_BIT]};

    // accumulator, held at zero by the reset bit, never cleared on switch
    if (s_r.ctrl_s[RESET_BIT]) begin
      s_nxt.acc = '0;
    end else begin
      s_nxt.acc = s_r.acc + s_r.inc;
    end

    // offset added to the top bits, carry dropped
    s_nxt.phase = s_r.acc[FREQ_W-1 -: PHASE_W] + s_r.ofs_d;

    // amplitude stage, midscale while held in reset
    if (s_r.rst_d[1]) begin
      s_nxt.code = MIDSCALE;
    end else if (s_r.ctrl[MODE_BIT]) begin
      s_nxt.code = dwc_tri(s_r.phase);
    end else begin
      s_nxt.code = dwc_sine(s_r.phase);
    end

    //------------------------------------------------------------------
    // output
    //------------------------------------------------------------------
    // output delay line sets the load-to-output latency
    s_nxt.pipe[0] = s_r.code;
    for (int i = 1; i < PIPE; i++) begin
      s_nxt.pipe[i] = s_r.pipe[i-1];
    end
  end

  //----------------------------------------------------------------------
  // frequency word merge
  //----------------------------------------------------------------------
  // merge a write into a frequency word by load mode
  function automatic logic [FREQ_W-1:0] upd(input logic [FREQ_W-1:0] old);
    logic [FREQ_W-1:0] r;
    r = old;
    if (s_r.ctrl[FULL_WIDTH_BIT]) begin
      r = {payload, s_r.low_stage};
    end else if (s_r.ctrl[HALF_SEL_BIT]) begin
      r[FREQ_W-1:HALF_W] = payload;
    end else begin
      r[HALF_W-1:0] = payload;
    end
    return r;
  endfunction

  //----------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      // state clear except sclk_q high, output path at midscale
      s_r <= '0;
      s_r.sclk_q <= 1'b1;
      s_r.ctrl <= CTRL_RST;
      s_r.ctrl_s <= CTRL_RST;
      s_r.code <= MIDSCALE;
      s_r.pipe <= {PIPE{MIDSCALE}};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== test/dwc_checker.sv
// assertions on the three-wire link between host and core
`timescale 1ns/100ps
module dwc_checker (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_din,
  input wire logic WORD_SEEN
);
  logic sclk_q;
  logic [3:0] cnt;
  logic fall;
  // framed falling edge of the serial clock
  assign fall = sclk_q && !sclk && !frame_sync_n;
  // count framed falls, cleared outside a frame
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sclk_q <= 1'b1;
      cnt <= 4'h0;
    end else begin
      sclk_q <= sclk;
      cnt <= frame_sync_n ? 4'h0 : cnt + 4'(fall);
    end
  end
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence s_start;
    $fell(frame_sync_n);
  endsequence
  sequence s_last;
    fall && cnt == 4'hf;
  endsequence
  chk_sclk_at_frame: assert property (s_start |-> sclk)
    else $error("serial clock low at frame start");
  chk_idle_high: assert property (frame_sync_n |-> sclk)
    else $error("serial clock not high outside frame");
  chk_whole_words: assert property ($rose(frame_sync_n) |-> cnt == 4'h0)
    else $error("frame ended inside a word");
  chk_frame_hold: assert property (s_start |-> !frame_sync_n [*8])
    else $error("frame raised too early");
  chk_first_fall: assert property (s_start |-> ##[1:8] fall)
    else $error("no serial clock fall after frame start");
  chk_word_pulse: assert property (s_last |=> WORD_SEEN)
    else $error("no word pulse after sixteenth fall");
  chk_no_stray: assert property (!(fall && cnt == 4'hf) |=> !WORD_SEEN)
    else $error("word pulse without sixteenth fall");
  chk_din_held: assert property ($fell(sclk) && !frame_sync_n |-> $stable(serial_din))
    else $error("data moved on falling edge");
  chk_din_on_rise: assert property (!frame_sync_n && !$fell(frame_sync_n)
    && $changed(serial_din) |-> $rose(sclk))
    else $error("data moved away from rising edge");
endmodule

// ===== test/testbench.sv
// self-checking bench: host and core joined over the serial link
`timescale 1ns/100ps
module testbench;
  import dwc_pkg::*;
  logic CLOCK;
  logic NRST;
  logic wr_valid;
  logic [15:0] wr_data;
  logic wr_ready;
  logic busy;
  logic [9:0] dac;
  logic [9:0] dac2;
  logic seen;
  logic seen2;
  int mismatches;
  int checks;
  int nseen;
  int nseen2;
  dwc_if link();
  dwc_if bad();
  dwc_host #(.DIV(2)) dwc_host_inst (.CLOCK(CLOCK), .NRST(NRST), .WR_VALID(wr_valid),
    .WR_DATA(wr_data), .WR_READY(wr_ready), .BUSY(busy), .LINK(link));
  dwc_core dwc_core_inst (.CLOCK(CLOCK), .NRST(NRST), .LINK(link), .DAC_CODE(dac),
    .WORD_SEEN(seen));
  dwc_core dwc_core_inst2 (.CLOCK(CLOCK), .NRST(NRST), .LINK(bad), .DAC_CODE(dac2),
    .WORD_SEEN(seen2));
  dwc_checker dwc_checker_inst (.CLOCK(CLOCK), .NRST(NRST), .sclk(link.sclk),
    .frame_sync_n(link.frame_sync_n), .serial_din(link.serial_din), .WORD_SEEN(seen));
  // clock and word pulse counters
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (seen === 1'b1) nseen++;
    if (seen2 === 1'b1) nseen2++;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // words back to back in one frame, then optionally wait for idle
  task automatic send(input logic [15:0] w[$], input bit fin = 1'b1);
    int t;
    @(posedge CLOCK);
    foreach (w[i]) begin
      wr_valid <= 1'b1;
      wr_data <= w[i];
      @(negedge CLOCK);
      for (t = 0; t < 400 && wr_ready !== 1'b1; t++) @(negedge CLOCK);
      if (t >= 400) begin
        mismatches++;
        $display("[ERR] %0t host never ready", $time);
      end
      @(posedge CLOCK);
    end
    wr_valid <= 1'b0;
    if (fin) begin
      @(negedge CLOCK);
      for (t = 0; t < 400 && busy !== 1'b0; t++) @(negedge CLOCK);
      if (t >= 400) begin
        mismatches++;
        $display("[ERR] %0t host stayed busy", $time);
      end
      repeat (10) @(negedge CLOCK);
    end
  endtask
  // cycles from the word pulse until the expected code shows
  task automatic lat(input logic [15:0] w, input logic [9:0] e);
    int n;
    send('{w}, 1'b0);
    for (n = 0; n < 300 && seen !== 1'b1; n++) @(negedge CLOCK);
    for (n = 0; n < 20 && dac !== e; n++) @(negedge CLOCK);
    chk(dac, e, "code");
    chk(10'(n == 8 || n == 9), 10'h1, "latency");
    repeat (4) @(negedge CLOCK);
  endtask
  // quarter turn per cycle: codes run 3ff, 200, 001, 200
  task automatic quarter;
    int n;
    logic [9:0] e[4];
    e = '{10'h3ff, 10'h200, 10'h001, 10'h200};
    for (n = 0; n < 8 && dac !== 10'h3ff; n++) @(negedge CLOCK);
    for (n = 0; n < 8; n++) begin
      chk(dac, e[n % 4], "step");
      @(negedge CLOCK);
    end
  endtask
  // one bit on the second link, frame level given
  task automatic bit_out(input logic fs, input logic v);
    @(posedge CLOCK);
    bad.serial_din <= v;
    bad.sclk <= 1'b1;
    bad.frame_sync_n <= fs;
    repeat (2) @(posedge CLOCK);
    bad.sclk <= 1'b0;
    @(posedge CLOCK);
  endtask
  // main sequence
  initial begin
    logic [15:0] w;
    NRST = 1'b0;
    wr_valid = 1'b0;
    wr_data = 16'h0;
    bad.sclk = 1'b1;
    bad.frame_sync_n = 1'b1;
    bad.serial_din = 1'b0;
    repeat (5) @(posedge CLOCK);
    NRST <= 1'b1;
    @(negedge CLOCK);
    chk(dac, MIDSCALE, "midscale");
    send('{16'h2100, 16'hc400, 16'he200});
    chk(10'(nseen), 10'h3, "words");
    chk(dac, MIDSCALE, "held");
    lat(16'h2000, 10'h3ff);
    lat(16'h2400, 10'h380);
    send('{16'h2402});
    chk(10'(dac !== 10'h380), 10'h1, "mode");
    send('{16'h2400});
    chk(dac, 10'h380, "sine");
    lat(16'hec00, 10'h001);
    send('{16'h9000, 16'h9000, 16'h0800});
    quarter();
    send('{16'h2100, 16'h4000, 16'h5000, 16'h2000});
    quarter();
    w = 16'hc400;
    for (int i = 0; i < 20; i++) bit_out(1'b1, i[0]);
    for (int i = 0; i < 8; i++) bit_out(1'b0, 1'b1);
    bit_out(1'b1, 1'b0);
    for (int i = 0; i < 16; i++) bit_out(1'b0, w[15-i]);
    bit_out(1'b1, 1'b1);
    repeat (12) @(negedge CLOCK);
    chk(10'(nseen2), 10'h1, "stray");
    chk(dac2, 10'h3ff, "framed word");
    close_out();
  end
  // watchdog
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
endmodule
